// [hw/mcpp_pkg.sv]
// Constants shared by the motion payload packer
package mcpp_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_SEND = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_FIELD_BASE = 12'h010;
  localparam logic [11:0] OFF_DIST_HELD = 12'h060;
  localparam logic [11:0] OFF_DIST_FREE = 12'h064;
  localparam int NUM_FIELDS = 20;
  // Field register indices
  localparam int F_POS_X = 0;
  localparam int F_POS_Y = 1;
  localparam int F_VEL_XY = 2;
  localparam int F_YAW_TRACK = 3;
  localparam int F_BODY_FR = 4;
  localparam int F_BODY_D = 5;
  localparam int F_LEVEL_FL = 6;
  localparam int F_LEVEL_D = 7;
  localparam int F_POINT_BASE = 8;
  localparam int F_SURF_HP = 18;
  localparam int F_SURF_R = 19;
  // Control and status bits
  localparam int CTRL_SURF_CFG_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FIELD_RESET = 32'h0000_0000;
  localparam int STAT_REFUSED_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_EMPTY_BIT = 2;
  // Message identifiers
  localparam logic [10:0] ID_TSC = 11'h60a;
  localparam logic [10:0] ID_DIST = 11'h60b;
  localparam logic [10:0] ID_POS = 11'h60c;
  localparam logic [10:0] ID_VEL_YAW = 11'h60d;
  localparam logic [10:0] ID_BODY_ACC = 11'h60e;
  localparam logic [10:0] ID_LEVEL_ACC = 11'h60f;
  localparam logic [10:0] ID_PT1 = 11'h620;
  localparam logic [10:0] ID_PT4 = 11'h623;
  localparam logic [10:0] ID_SURF = 11'h624;
  // Frame lengths in bytes
  localparam logic [3:0] DLC_FULL = 4'h8;
  localparam logic [3:0] DLC_SIX = 4'h6;
  // Hold threshold, 0.2 m/s in 0.01 m/s counts
  localparam logic [15:0] HOLD_SPEED_CMS = 16'h0014;
  // Attitude limits in 0.01 degree counts
  localparam logic [15:0] SURF_HEAD_MAX = 16'h8ca0;
  localparam logic signed [15:0] SURF_PITCH_LIM = 16'sh2328;
  localparam logic signed [15:0] SURF_ROLL_LIM = 16'sh4650;
  // Queued frame: id, length, payload
  localparam int FRAME_W = 11 + 4 + 64;
  localparam int FIFO_DEPTH = 16;
endpackage : mcpp_pkg

// [hw/mcpp_frame_if.sv]
// Valid/ready carrier for queued frames
interface mcpp_frame_if #(parameter int WIDTH = 79);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : mcpp_frame_if

// [hw/mcpp_fifo.sv]
// Frame FIFO with registered storage
module mcpp_fifo #(
  parameter int WIDTH = 79,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Fill side
  mcpp_frame_if.snk in_if,
  // Drain side
  mcpp_frame_if.src out_if,
  // Level flags
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign full = (count_reg == (AW+1)'(DEPTH));
  assign empty = (count_reg == '0);
  assign in_if.ready = !full;
  assign out_if.valid = !empty;
  assign out_if.data = mem[rd_ptr_reg];
  assign push = in_if.valid && !full;
  assign pop = out_if.ready && !empty;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_if.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : mcpp_fifo

// [hw/mcpp_dist_acc.sv]
// Distance accumulator, optionally holding at low speed
module mcpp_dist_acc #(
  parameter bit HOLD = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Displacement samples
  input wire logic step_valid,
  input wire logic [15:0] step_mm,
  input wire logic [15:0] speed_cms,
  // Running total in mm
  output logic [31:0] total
);
  logic [31:0] total_reg;
  logic add_en;

  // Wraps at 32 bits like the transmitted field
  assign add_en = step_valid && !(HOLD && (speed_cms < mcpp_pkg::HOLD_SPEED_CMS));
  assign total = total_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      total_reg <= '0;
    end else if (add_en) begin
      total_reg <= total_reg + {16'h0000, step_mm};
    end
  end
endmodule : mcpp_dist_acc

// [hw/mcpp_top.sv]
// Motion payload packer: APB registers, distance accumulators, frame builder
module mcpp_top #(
  parameter int FIFO_DEPTH = mcpp_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Displacement samples
  input wire logic DISP_VALID,
  input wire logic [15:0] DISP_MM,
  input wire logic [15:0] SPEED_CMS,
  // Frames to the CAN controller
  output logic FRAME_VALID,
  input wire logic FRAME_READY,
  output logic [10:0] FRAME_ID,
  output logic [3:0] FRAME_DLC,
  output logic [63:0] FRAME_DATA
);
  logic [31:0] ctrl_reg;
  logic [31:0] field_reg [mcpp_pkg::NUM_FIELDS];
  logic refused_reg;
  logic [31:0] dist_held;
  logic [31:0] dist_free;
  logic access;
  logic wr_access;
  logic send_hit;
  logic field_hit;
  logic [4:0] field_idx;
  logic addr_ok;
  logic fifo_full;
  logic fifo_empty;
  logic [10:0] send_id;
  logic [63:0] payload;
  logic [3:0] dlc;
  logic id_ok;
  logic [2:0] pt;
  logic [15:0] surf_head;
  logic [15:0] surf_pitch;
  logic [15:0] surf_roll;

  mcpp_frame_if #(.WIDTH(mcpp_pkg::FRAME_W)) fill_if ();
  mcpp_frame_if #(.WIDTH(mcpp_pkg::FRAME_W)) drain_if ();

  // Address decode
  assign access = PSEL && PENABLE;
  assign wr_access = access && PWRITE;
  assign field_idx = 5'((PADDR - mcpp_pkg::OFF_FIELD_BASE) >> 2);
  assign field_hit = (PADDR >= mcpp_pkg::OFF_FIELD_BASE) && (PADDR < mcpp_pkg::OFF_DIST_HELD)
    && (PADDR[1:0] == 2'b00);
  assign send_hit = (PADDR == mcpp_pkg::OFF_SEND);
  assign addr_ok = field_hit || send_hit || (PADDR == mcpp_pkg::OFF_CTRL)
    || (PADDR == mcpp_pkg::OFF_STATUS) || (PADDR == mcpp_pkg::OFF_DIST_HELD)
    || (PADDR == mcpp_pkg::OFF_DIST_FREE);

  // A send waits in the access phase while the queue is full, so no frame is lost
  assign PREADY = !(wr_access && send_hit && fifo_full);
  assign PSLVERR = access && !addr_ok;

  always_comb begin
    PRDATA = 32'h0000_0000;
    if (access && !PWRITE) begin
      if (field_hit) begin
        PRDATA = field_reg[field_idx];
      end else if (PADDR == mcpp_pkg::OFF_CTRL) begin
        PRDATA = ctrl_reg;
      end else if (PADDR == mcpp_pkg::OFF_STATUS) begin
        PRDATA[mcpp_pkg::STAT_REFUSED_BIT] = refused_reg;
        PRDATA[mcpp_pkg::STAT_FULL_BIT] = fifo_full;
        PRDATA[mcpp_pkg::STAT_EMPTY_BIT] = fifo_empty;
      end else if (PADDR == mcpp_pkg::OFF_DIST_HELD) begin
        PRDATA = dist_held;
      end else if (PADDR == mcpp_pkg::OFF_DIST_FREE) begin
        PRDATA = dist_free;
      end
    end
  end

  // Control register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      ctrl_reg <= mcpp_pkg::CTRL_RESET;
    end else if (wr_access && PADDR == mcpp_pkg::OFF_CTRL) begin
      ctrl_reg <= {31'h0000_0000, PWDATA[mcpp_pkg::CTRL_SURF_CFG_BIT]};
    end
  end

  // Field registers hold already-scaled integers
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      for (int i = 0; i < mcpp_pkg::NUM_FIELDS; i++) begin
        field_reg[i] <= mcpp_pkg::FIELD_RESET;
      end
    end else if (wr_access && field_hit) begin
      field_reg[field_idx] <= PWDATA;
    end
  end

  // Distance totals
  mcpp_dist_acc #(.HOLD(1'b1)) u_held (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .step_valid(DISP_VALID),
    .step_mm(DISP_MM),
    .speed_cms(SPEED_CMS),
    .total(dist_held)
  );

  mcpp_dist_acc #(.HOLD(1'b0)) u_free (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .step_valid(DISP_VALID),
    .step_mm(DISP_MM),
    .speed_cms(SPEED_CMS),
    .total(dist_free)
  );

  // Attitude limits
  always_comb begin
    surf_head = field_reg[mcpp_pkg::F_SURF_HP][15:0];
    surf_pitch = field_reg[mcpp_pkg::F_SURF_HP][31:16];
    surf_roll = field_reg[mcpp_pkg::F_SURF_R][15:0];
    if (surf_head > mcpp_pkg::SURF_HEAD_MAX) begin
      surf_head = mcpp_pkg::SURF_HEAD_MAX;
    end
    if ($signed(surf_pitch) > mcpp_pkg::SURF_PITCH_LIM) begin
      surf_pitch = mcpp_pkg::SURF_PITCH_LIM;
    end else if ($signed(surf_pitch) < -mcpp_pkg::SURF_PITCH_LIM) begin
      surf_pitch = -mcpp_pkg::SURF_PITCH_LIM;
    end
    if ($signed(surf_roll) > mcpp_pkg::SURF_ROLL_LIM) begin
      surf_roll = mcpp_pkg::SURF_ROLL_LIM;
    end else if ($signed(surf_roll) < -mcpp_pkg::SURF_ROLL_LIM) begin
      surf_roll = -mcpp_pkg::SURF_ROLL_LIM;
    end
  end

  // Payload builder; point 0 is the reference-point frame
  assign send_id = PWDATA[10:0];
  assign pt = (send_id == mcpp_pkg::ID_TSC) ? 3'h0 : 3'(send_id - mcpp_pkg::ID_PT1 + 11'h001);

  always_comb begin
    payload = 64'h0000_0000_0000_0000;
    dlc = mcpp_pkg::DLC_SIX;
    id_ok = 1'b1;
    if (send_id == mcpp_pkg::ID_DIST) begin
      payload = {dist_free, dist_held};
      dlc = mcpp_pkg::DLC_FULL;
    end else if (send_id == mcpp_pkg::ID_POS) begin
      payload = {field_reg[mcpp_pkg::F_POS_Y], field_reg[mcpp_pkg::F_POS_X]};
      dlc = mcpp_pkg::DLC_FULL;
    end else if (send_id == mcpp_pkg::ID_VEL_YAW) begin
      payload = {field_reg[mcpp_pkg::F_YAW_TRACK], field_reg[mcpp_pkg::F_VEL_XY]};
      dlc = mcpp_pkg::DLC_FULL;
    end else if (send_id == mcpp_pkg::ID_BODY_ACC) begin
      payload[47:0] = {field_reg[mcpp_pkg::F_BODY_D][15:0], field_reg[mcpp_pkg::F_BODY_FR]};
    end else if (send_id == mcpp_pkg::ID_LEVEL_ACC) begin
      payload[47:0] = {field_reg[mcpp_pkg::F_LEVEL_D][15:0], field_reg[mcpp_pkg::F_LEVEL_FL]};
    end else if (send_id == mcpp_pkg::ID_TSC
        || (send_id >= mcpp_pkg::ID_PT1 && send_id <= mcpp_pkg::ID_PT4)) begin
      // Slip goes out raw; reversing puts it near 180 degrees
      payload[47:0] = {field_reg[mcpp_pkg::F_POINT_BASE + 2 * pt + 1][15:0],
        field_reg[mcpp_pkg::F_POINT_BASE + 2 * pt]};
    end else if (send_id == mcpp_pkg::ID_SURF) begin
      payload[47:0] = {surf_roll, surf_pitch, surf_head};
      id_ok = ctrl_reg[mcpp_pkg::CTRL_SURF_CFG_BIT];
    end else begin
      id_ok = 1'b0;
    end
  end

  // Queue push on the completing send write
  assign fill_if.valid = wr_access && send_hit && id_ok;
  assign fill_if.data = {send_id, dlc, payload};

  // Sticky refusal, cleared by a good send; a new refusal wins
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      refused_reg <= 1'b0;
    end else if (wr_access && send_hit) begin
      refused_reg <= !id_ok;
    end
  end

  mcpp_fifo #(.WIDTH(mcpp_pkg::FRAME_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .in_if(fill_if),
    .out_if(drain_if),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  assign FRAME_VALID = drain_if.valid;
  assign drain_if.ready = FRAME_READY;
  assign FRAME_ID = drain_if.data[78:68];
  assign FRAME_DLC = drain_if.data[67:64];
  assign FRAME_DATA = drain_if.data[63:0];
endmodule : mcpp_top

// [dv/mcpp_asserts.sv]
// Port-level checks of the packer's bus and frame output
module mcpp_asserts (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  // Frames
  input wire logic FRAME_VALID,
  input wire logic FRAME_READY,
  input wire logic [10:0] FRAME_ID,
  input wire logic [3:0] FRAME_DLC,
  input wire logic [63:0] FRAME_DATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  logic signed [15:0] pitch;
  logic signed [15:0] roll;
  logic full_len;
  logic surf;
  assign pitch = FRAME_DATA[31:16];
  assign roll = FRAME_DATA[47:32];
  assign full_len = FRAME_ID inside {mcpp_pkg::ID_DIST, mcpp_pkg::ID_POS, mcpp_pkg::ID_VEL_YAW};
  assign surf = FRAME_VALID && FRAME_ID == mcpp_pkg::ID_SURF;
  sequence send_dist;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == mcpp_pkg::OFF_SEND && PWDATA[10:0] == mcpp_pkg::ID_DIST;
  endsequence
  sequence stalled;
    FRAME_VALID && !FRAME_READY;
  endsequence
  AST_SEND_PUSH: assert property (send_dist |=> FRAME_VALID)
    else $error("send left no frame queued");
  AST_HOLD: assert property (stalled |=> FRAME_VALID && $stable(FRAME_ID) && $stable(FRAME_DATA))
    else $error("frame changed while stalled");
  AST_WAIT_SEND: assert property (!PREADY |-> PSEL && PENABLE && PWRITE && PADDR == mcpp_pkg::OFF_SEND)
    else $error("wait state outside a send");
  AST_DLC_FULL: assert property (FRAME_VALID && full_len |-> FRAME_DLC == mcpp_pkg::DLC_FULL)
    else $error("eight byte frame has wrong length");
  AST_DLC_SIX: assert property (FRAME_VALID && !full_len |->
    FRAME_DLC == mcpp_pkg::DLC_SIX && FRAME_DATA[63:48] == 16'h0)
    else $error("six byte frame wrong");
  AST_ID_KNOWN: assert property (FRAME_VALID |-> FRAME_ID inside {[11'h60a:11'h60f], [11'h620:11'h624]})
    else $error("frame with unknown id");
  AST_HEAD: assert property (surf |-> FRAME_DATA[15:0] <= mcpp_pkg::SURF_HEAD_MAX)
    else $error("heading out of range");
  AST_PITCH: assert property (surf |->
    pitch <= mcpp_pkg::SURF_PITCH_LIM && pitch >= -mcpp_pkg::SURF_PITCH_LIM)
    else $error("pitch out of range");
  AST_ROLL: assert property (surf |->
    roll <= mcpp_pkg::SURF_ROLL_LIM && roll >= -mcpp_pkg::SURF_ROLL_LIM)
    else $error("roll out of range");
  AST_RST_EMPTY: assert property ($rose(RST_B) |-> !FRAME_VALID)
    else $error("frame pending after reset");
endmodule : mcpp_asserts

// [dv/mcpp_rx_model.sv]
// Frame receiver standing in for the CAN controller
module mcpp_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bench control: hold off all frames
  input wire logic stall,
  // Frame port
  input wire logic valid,
  input wire logic [10:0] id,
  input wire logic [3:0] dlc,
  input wire logic [63:0] data,
  output logic ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [78:0] got[$];
  initial ready = 1'b0;
  // Random gaps so both prompt and slow pops occur
  always @(posedge clk) begin
    if (valid && ready) got.push_back({id, dlc, data});
    ready <= rst_b && !stall && ($urandom % 4 != 0);
  end
endmodule : mcpp_rx_model

// [dv/motion_can_payload_packer_test.sv]
// Self-checking bench of the motion payload packer
module motion_can_payload_packer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 4;
  logic SYS_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic DISP_VALID = 1'b0;
  logic [15:0] DISP_MM = 16'h0;
  logic [15:0] SPEED_CMS = 16'h0;
  logic stall = 1'b1;
  logic [31:0] PRDATA, rd, held, free;
  logic PREADY, PSLVERR, err, FRAME_VALID, FRAME_READY;
  logic [10:0] FRAME_ID;
  logic [3:0] FRAME_DLC;
  logic [63:0] FRAME_DATA;
  logic [31:0] f [20];
  logic [78:0] expq[$];
  logic [10:0] ids [10] = '{11'h60a, 11'h60b, 11'h60c, 11'h60d, 11'h60e, 11'h60f, 11'h620, 11'h621, 11'h622, 11'h623};
  int failures = 0;
  int n_compared = 0;
  always #25 SYS_CLK = ~SYS_CLK;
  mcpp_top #(.FIFO_DEPTH(DEPTH)) dut_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DISP_VALID(DISP_VALID), .DISP_MM(DISP_MM), .SPEED_CMS(SPEED_CMS), .FRAME_VALID(FRAME_VALID),
    .FRAME_READY(FRAME_READY), .FRAME_ID(FRAME_ID), .FRAME_DLC(FRAME_DLC), .FRAME_DATA(FRAME_DATA));
  mcpp_rx_model rx_u (.clk(SYS_CLK), .rst_b(RST_B), .stall(stall), .valid(FRAME_VALID), .id(FRAME_ID),
    .dlc(FRAME_DLC), .data(FRAME_DATA), .ready(FRAME_READY));
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task chk(input logic [78:0] seen, input logic [78:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One idle cycle after each transfer keeps drivers free of same-step reassignment
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 400);
    if (n >= 400) begin
      failures++;
      wrap_up();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask : apb
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic signed [15:0] lim);
    if ($signed(v) > lim) return lim;
    if ($signed(v) < -lim) return -lim;
    return v;
  endfunction : clamp
  function automatic logic [78:0] frame(input logic [10:0] id);
    logic [63:0] d;
    int k;
    k = id == mcpp_pkg::ID_TSC ? 8 : id < 11'h620 ? 2 * (id - 11'h60e) + 4 : 2 * (id - 11'h620) + 10;
    d = {16'h0, f[k + 1][15:0], f[k]};
    if (id == mcpp_pkg::ID_DIST) d = {free, held};
    if (id == mcpp_pkg::ID_POS) d = {f[1], f[0]};
    if (id == mcpp_pkg::ID_VEL_YAW) d = {f[3], f[2]};
    if (id == mcpp_pkg::ID_SURF) d = {16'h0, clamp(f[19][15:0], mcpp_pkg::SURF_ROLL_LIM),
      clamp(f[18][31:16], mcpp_pkg::SURF_PITCH_LIM),
      f[18][15:0] > mcpp_pkg::SURF_HEAD_MAX ? mcpp_pkg::SURF_HEAD_MAX : f[18][15:0]};
    return {id, id inside {11'h60b, 11'h60c, 11'h60d} ? mcpp_pkg::DLC_FULL : mcpp_pkg::DLC_SIX, d};
  endfunction : frame
  task send(input logic [10:0] id, input logic ok);
    apb(1'b1, mcpp_pkg::OFF_SEND, {21'h0, id});
    if (ok) expq.push_back(frame(id));
    apb(1'b0, mcpp_pkg::OFF_STATUS, 32'h0);
    chk(rd[mcpp_pkg::STAT_REFUSED_BIT], !ok);
  endtask : send
  task drain;
    int n;
    n = 0;
    stall <= 1'b0;
    while (FRAME_VALID !== 1'b0 && n < 500) begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n >= 500) begin
      failures++;
      wrap_up();
    end
    @(posedge SYS_CLK);
    chk(rx_u.got.size(), expq.size());
    foreach (expq[i]) chk(rx_u.got[i], expq[i]);
    apb(1'b0, mcpp_pkg::OFF_STATUS, 32'h0);
    chk(rd[mcpp_pkg::STAT_EMPTY_BIT], 1'b1);
    rx_u.got.delete();
    expq.delete();
  endtask : drain
  initial begin
    void'($urandom(32'h18d2));
    held = 32'h0;
    free = 32'h0;
    repeat (8) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    @(posedge SYS_CLK);
    apb(1'b0, mcpp_pkg::OFF_DIST_HELD, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk(err, 1'b1);
    for (int i = 0; i < 24; i++) begin
      DISP_VALID <= 1'b1;
      DISP_MM <= $urandom;
      SPEED_CMS <= i < 2 ? 16'h13 + 16'(i) : 16'($urandom % 40);
      @(posedge SYS_CLK);
      free += DISP_MM;
      if (SPEED_CMS >= mcpp_pkg::HOLD_SPEED_CMS) held += DISP_MM;
    end
    DISP_VALID <= 1'b0;
    @(posedge SYS_CLK);
    apb(1'b0, mcpp_pkg::OFF_DIST_HELD, 32'h0);
    chk(rd, held);
    apb(1'b0, mcpp_pkg::OFF_DIST_FREE, 32'h0);
    chk(rd, free);
    for (int i = 0; i < 20; i++) f[i] = $urandom;
    // Slip near plus and minus 180 degrees must pass untouched
    f[10][31:16] = 16'h464f;
    f[12][31:16] = 16'hb9b1;
    // Heading and roll above their upper limits, pitch below its lower limit, so each field is clamped
    f[18] = 32'h8000_ffff;
    f[19][15:0] = 16'h7fff;
    for (int i = 0; i < 20; i++) apb(1'b1, 12'(mcpp_pkg::OFF_FIELD_BASE + 4 * i), f[i]);
    stall <= 1'b0;
    foreach (ids[i]) send(ids[i], 1'b1);
    send(mcpp_pkg::ID_SURF, 1'b0);
    send(11'h610, 1'b0);
    apb(1'b1, mcpp_pkg::OFF_CTRL, 32'h1);
    send(mcpp_pkg::ID_SURF, 1'b1);
    drain();
    stall <= 1'b1;
    for (int i = 0; i < DEPTH; i++) send(ids[i], 1'b1);
    chk(rd[mcpp_pkg::STAT_FULL_BIT], 1'b1);
    fork
      send(mcpp_pkg::ID_DIST, 1'b1);
      begin
        repeat (20) @(posedge SYS_CLK);
        stall <= 1'b0;
      end
    join
    drain();
    wrap_up();
  end
endmodule : motion_can_payload_packer_test

bind mcpp_top mcpp_asserts chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .FRAME_VALID(FRAME_VALID),
  .FRAME_READY(FRAME_READY), .FRAME_ID(FRAME_ID), .FRAME_DLC(FRAME_DLC), .FRAME_DATA(FRAME_DATA));
